// *** logic/adc_result_bank_defs.svh ***
// register offsets, field positions and reset values of the result bank
// assumes inclusion by bare name from the design file
`ifndef ADC_RESULT_BANK_DEFS_SVH
`define ADC_RESULT_BANK_DEFS_SVH

// ----------------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------------
`define ADDR_W 5
`define DATA_W 8

// ----------------------------------------------------------------------
// byte register offsets
// ----------------------------------------------------------------------
`define OFS_RES_HI 5'h00
`define OFS_RES_LO 5'h01
`define OFS_PREV_HI 5'h02
`define OFS_PREV_LO 5'h03
`define OFS_ACC_HI 5'h04
`define OFS_ACC_LO 5'h05
`define OFS_STPT_HI 5'h06
`define OFS_STPT_LO 5'h07
`define OFS_ERR_HI 5'h08
`define OFS_ERR_LO 5'h09
`define OFS_LTH_HI 5'h0a
`define OFS_LTH_LO 5'h0b
`define OFS_UTH_HI 5'h0c
`define OFS_UTH_LO 5'h0d
`define OFS_CTRL2 5'h0e
`define OFS_CTRL3 5'h0f
`define OFS_CROSS 5'h10
`define OFS_IRQ_STAT 5'h11
`define OFS_IRQ_CLR 5'h12
`define OFS_IRQ_EN 5'h13

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define C2_JUST 0
`define C2_PSRC 1
`define C2_SHIFT_LSB 2
`define C2_MODE_LSB 5
`define C3_CALC_LSB 0
`define C3_TMD_LSB 4
`define CROSS_LOWER 0
`define CROSS_UPPER 1
`define IRQ_DONE 0
`define IRQ_THR 1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CTRL_RST 8'h00
`define DATA_RST 8'h00
`define IRQ_RST 2'h0

`endif

// *** logic/adc_result_pkg.sv ***
// mode encodings of the result bank
// assumes nothing of its surroundings
`default_nettype none

package adc_result_pkg;

    // accumulator behaviour per conversion
    typedef enum logic [2:0] {
        FM_BASIC = 3'h0,
        FM_ACCUM = 3'h1,
        FM_AVG = 3'h2,
        FM_BURST = 3'h3,
        FM_LPF = 3'h4
    } filt_mode_t;

    // source of the calculation error
    typedef enum logic [2:0] {
        CM_DERIV = 3'h0,
        CM_VAL_STPT = 3'h1,
        CM_FILT_PREV = 3'h2,
        CM_FILT_STPT = 3'h3
    } calc_mode_t;

    // threshold interrupt condition
    typedef enum logic [2:0] {
        TM_NEVER = 3'h0,
        TM_BELOW = 3'h1,
        TM_ABOVE = 3'h2,
        TM_OUTSIDE = 3'h3,
        TM_INSIDE = 3'h4
    } thr_mode_t;

endpackage : adc_result_pkg

`default_nettype wire

// *** logic/adc_result_bank.sv ***
// result, previous, accumulator, setpoint and error registers of the adc
// assumes conversion strobes come from logic on clk, byte-wide register port
`timescale 1ns/10ps
`default_nettype none
`include "adc_result_bank_defs.svh"

module adc_result_bank (
    input wire logic clk, // system clock
    input wire logic rst, // power-on or brown-out reset
    input wire logic warm_rst, // any other reset, synchronous
    input wire logic conv_start, // pulse: new conversion begins
    input wire logic conv_done, // pulse: conversion value ready
    input wire logic [9:0] conv_data, // conversion value
    input wire logic [`ADDR_W-1:0] addr, // register address
    input wire logic [`DATA_W-1:0] wdata, // write data
    input wire logic wr_en, // write strobe
    input wire logic rd_en, // read strobe
    output logic [`DATA_W-1:0] rdata, // read data, cycle after strobe
    output logic irq // level interrupt
);

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [7:0] res_hi_q, res_lo_q, prev_hi_q, prev_lo_q;
    logic signed [15:0] acc_q, err_q;
    logic [7:0] stpt_hi_q, stpt_lo_q;
    logic [15:0] lth_q, uth_q;
    logic [7:0] ctrl2_q, ctrl3_q, irq_en_q, rdata_q;
    logic [9:0] val_q;
    logic done_q, err_vld_q, upper_q, lower_q;
    logic [1:0] irq_stat_q;

    // ------------------------------------------------------------------
    // control decode
    // ------------------------------------------------------------------
    logic justify, prior_src;
    logic [2:0] shift;
    adc_result_pkg::filt_mode_t fmode;
    adc_result_pkg::calc_mode_t cmode;
    adc_result_pkg::thr_mode_t tmode;
    logic signed [15:0] filt, val_ext, stpt, prev;
    logic up_now, lo_now, thr_evt;
    logic [1:0] irq_set, irq_clr;
    logic [7:0] rd_mux;

    assign justify = ctrl2_q[`C2_JUST];
    assign prior_src = ctrl2_q[`C2_PSRC];
    assign shift = ctrl2_q[`C2_SHIFT_LSB +: 3];
    assign fmode = adc_result_pkg::filt_mode_t'(ctrl2_q[`C2_MODE_LSB +: 3]);
    assign cmode = adc_result_pkg::calc_mode_t'(ctrl3_q[`C3_CALC_LSB +: 3]);
    assign tmode = adc_result_pkg::thr_mode_t'(ctrl3_q[`C3_TMD_LSB +: 3]);
    assign val_ext = $signed({6'h00, val_q});
    assign stpt = $signed({stpt_hi_q, stpt_lo_q});
    assign prev = $signed({prev_hi_q, prev_lo_q});
    // arithmetic shift keeps the sign of a negative sum
    assign filt = acc_q >>> shift;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic wr_hit(input logic [`ADDR_W-1:0] ofs);
        return wr_en && (addr == ofs);
    endfunction : wr_hit

    function automatic logic [15:0] fmt(input logic [9:0] v,
                                        input logic rj);
        if (rj) begin
            return {6'h00, v};
        end
        return {v, 6'h00};
    endfunction : fmt

    function automatic logic signed [15:0] calc_err(
            input adc_result_pkg::calc_mode_t m,
            input logic signed [15:0] v, f, p, s);
        case (m)
            adc_result_pkg::CM_DERIV: return v - p;
            adc_result_pkg::CM_FILT_PREV: return f - p;
            adc_result_pkg::CM_FILT_STPT: return f - s;
            default: return v - s;
        endcase
    endfunction : calc_err

    function automatic logic thr_hit(input adc_result_pkg::thr_mode_t m,
                                     input logic up, lo);
        case (m)
            adc_result_pkg::TM_BELOW: return lo;
            adc_result_pkg::TM_ABOVE: return up;
            adc_result_pkg::TM_OUTSIDE: return up | lo;
            adc_result_pkg::TM_INSIDE: return !up && !lo;
            default: return 1'b0;
        endcase
    endfunction : thr_hit

    // ------------------------------------------------------------------
    // result bytes and raw value
    // ------------------------------------------------------------------
    // conversion beats a software write in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            res_hi_q <= `DATA_RST;
            res_lo_q <= `DATA_RST;
            val_q <= 10'h000;
        end else if (conv_done) begin
            {res_hi_q, res_lo_q} <= fmt(conv_data, justify);
            val_q <= conv_data;
        end else begin
            if (wr_hit(`OFS_RES_HI)) res_hi_q <= wdata;
            if (wr_hit(`OFS_RES_LO)) res_lo_q <= wdata;
        end
    end

    // ------------------------------------------------------------------
    // previous result capture, no software write path
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {prev_hi_q, prev_lo_q} <= 16'h0000;
        end else if (conv_start) begin
            if (prior_src) begin
                {prev_hi_q, prev_lo_q} <= filt;
            end else begin
                {prev_hi_q, prev_lo_q} <= {res_hi_q, res_lo_q};
            end
        end
    end

    // ------------------------------------------------------------------
    // accumulator
    // ------------------------------------------------------------------
    // sum wraps at 16 bits; software must keep the shift sized to it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_q <= 16'sh0000;
        end else if (conv_done) begin
            case (fmode)
                adc_result_pkg::FM_ACCUM,
                adc_result_pkg::FM_AVG,
                adc_result_pkg::FM_BURST: begin
                    acc_q <= acc_q + $signed({6'h00, conv_data});
                end
                adc_result_pkg::FM_LPF: begin
                    acc_q <= acc_q - filt
                             + $signed({6'h00, conv_data});
                end
                default: acc_q <= acc_q;
            endcase
        end else begin
            if (wr_hit(`OFS_ACC_HI)) acc_q[15:8] <= wdata;
            if (wr_hit(`OFS_ACC_LO)) acc_q[7:0] <= wdata;
        end
    end

    // ------------------------------------------------------------------
    // setpoint and thresholds
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stpt_hi_q <= `DATA_RST;
            stpt_lo_q <= `DATA_RST;
            lth_q <= 16'h0000;
            uth_q <= 16'h0000;
        end else begin
            if (wr_hit(`OFS_STPT_HI)) stpt_hi_q <= wdata;
            if (wr_hit(`OFS_STPT_LO)) stpt_lo_q <= wdata;
            if (wr_hit(`OFS_LTH_HI)) lth_q[15:8] <= wdata;
            if (wr_hit(`OFS_LTH_LO)) lth_q[7:0] <= wdata;
            if (wr_hit(`OFS_UTH_HI)) uth_q[15:8] <= wdata;
            if (wr_hit(`OFS_UTH_LO)) uth_q[7:0] <= wdata;
        end
    end

    // ------------------------------------------------------------------
    // error calculation, one cycle after the sum settles
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done_q <= 1'b0;
            err_vld_q <= 1'b0;
            err_q <= 16'sh0000;
        end else begin
            done_q <= conv_done;
            err_vld_q <= done_q;
            if (done_q) begin
                err_q <= calc_err(cmode, val_ext, filt, prev, stpt);
            end
        end
    end

    // ------------------------------------------------------------------
    // threshold comparison
    // ------------------------------------------------------------------
    assign up_now = err_q > $signed(uth_q);
    assign lo_now = err_q < $signed(lth_q);
    assign thr_evt = err_vld_q && thr_hit(tmode, up_now, lo_now);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            upper_q <= 1'b0;
            lower_q <= 1'b0;
        end else if (warm_rst) begin
            upper_q <= 1'b0;
            lower_q <= 1'b0;
        end else if (err_vld_q) begin
            upper_q <= up_now;
            lower_q <= lo_now;
        end
    end

    // ------------------------------------------------------------------
    // control registers, cleared by every reset
    // ------------------------------------------------------------------
    // data registers above, except the crossing flags, ignore warm_rst so values survive it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl2_q <= `CTRL_RST;
            ctrl3_q <= `CTRL_RST;
            irq_en_q <= `CTRL_RST;
        end else if (warm_rst) begin
            ctrl2_q <= `CTRL_RST;
            ctrl3_q <= `CTRL_RST;
            irq_en_q <= `CTRL_RST;
        end else begin
            if (wr_hit(`OFS_CTRL2)) ctrl2_q <= wdata;
            if (wr_hit(`OFS_CTRL3)) ctrl3_q <= wdata;
            if (wr_hit(`OFS_IRQ_EN)) irq_en_q <= wdata;
        end
    end

    // ------------------------------------------------------------------
    // interrupt status: set wins over clear
    // ------------------------------------------------------------------
    assign irq_set = {thr_evt, done_q};
    // spelled out: a function call would hide wr_en and addr from the assign
    assign irq_clr = (wr_en && addr == `OFS_IRQ_CLR) ? wdata[1:0] : 2'h0;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_stat_q <= `IRQ_RST;
        end else if (warm_rst) begin
            irq_stat_q <= `IRQ_RST;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
        end
    end

    assign irq = |(irq_stat_q & irq_en_q[1:0]);

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    // unmapped and write-only offsets read as zero
    always_comb begin
        if (addr == `OFS_RES_HI) rd_mux = res_hi_q;
        else if (addr == `OFS_RES_LO) rd_mux = res_lo_q;
        else if (addr == `OFS_PREV_HI) rd_mux = prev_hi_q;
        else if (addr == `OFS_PREV_LO) rd_mux = prev_lo_q;
        else if (addr == `OFS_ACC_HI) rd_mux = acc_q[15:8];
        else if (addr == `OFS_ACC_LO) rd_mux = acc_q[7:0];
        else if (addr == `OFS_STPT_HI) rd_mux = stpt_hi_q;
        else if (addr == `OFS_STPT_LO) rd_mux = stpt_lo_q;
        else if (addr == `OFS_ERR_HI) rd_mux = err_q[15:8];
        else if (addr == `OFS_ERR_LO) rd_mux = err_q[7:0];
        else if (addr == `OFS_LTH_HI) rd_mux = lth_q[15:8];
        else if (addr == `OFS_LTH_LO) rd_mux = lth_q[7:0];
        else if (addr == `OFS_UTH_HI) rd_mux = uth_q[15:8];
        else if (addr == `OFS_UTH_LO) rd_mux = uth_q[7:0];
        else if (addr == `OFS_CTRL2) rd_mux = ctrl2_q;
        else if (addr == `OFS_CTRL3) rd_mux = ctrl3_q;
        else if (addr == `OFS_CROSS) rd_mux = {6'h00, upper_q, lower_q};
        else if (addr == `OFS_IRQ_STAT) rd_mux = {6'h00, irq_stat_q};
        else if (addr == `OFS_IRQ_EN) rd_mux = irq_en_q;
        else rd_mux = 8'h00;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rd_en ? rd_mux : 8'h00;
        end
    end

    assign rdata = rdata_q;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_right_low_byte: assert property (
        conv_done && justify |=> res_lo_q == $past(conv_data[7:0]))
        else $error("right justified low byte wrong");
    a_right_high_byte: assert property (
        conv_done && justify |=> res_hi_q == {6'h00, $past(conv_data[9:8])})
        else $error("right justified high byte wrong");
    a_prev_filter_copy: assert property (
        conv_start && prior_src |=> {prev_hi_q, prev_lo_q} == $past(filt))
        else $error("previous value not taken from filter");
    a_prev_result_copy: assert property (
        conv_start && !prior_src
        |=> {prev_hi_q, prev_lo_q} == $past({res_hi_q, res_lo_q}))
        else $error("previous value not taken from result");
    a_prev_read_only: assert property (
        wr_en && addr == `OFS_PREV_LO && !conv_start |=> $stable(prev_lo_q))
        else $error("previous value changed by write");
    a_acc_sum_step: assert property (
        conv_done && fmode == adc_result_pkg::FM_ACCUM
        |=> acc_q == $past(acc_q) + $signed({6'h00, $past(conv_data)}))
        else $error("accumulator did not add value");
    a_acc_low_read: assert property (
        rd_en && addr == `OFS_ACC_LO |=> rdata == $past(acc_q[7:0]))
        else $error("accumulator low byte read wrong");
    a_acc_byte_split: assert property (
        wr_en && addr == `OFS_ACC_HI && !conv_done
        |=> acc_q[7:0] == $past(acc_q[7:0]) && acc_q[15:8] == $past(wdata))
        else $error("high byte write disturbed low byte");
    a_setpoint_write: assert property (
        wr_en && addr == `OFS_STPT_HI |=> stpt_hi_q == $past(wdata))
        else $error("setpoint high byte not written");
    a_err_vs_setpoint: assert property (
        conv_done && !wr_en && cmode == adc_result_pkg::CM_VAL_STPT
        ##1 !wr_en |=> err_q == $signed({6'h00, $past(conv_data, 2)}) - stpt)
        else $error("error against setpoint wrong");
    a_upper_cross_flag: assert property (
        err_vld_q && !warm_rst
        |=> upper_q == ($past(err_q) > $signed($past(uth_q))))
        else $error("upper crossing flag wrong");
    a_warm_keeps_acc: assert property (
        warm_rst && !conv_done && !wr_en |=> $stable(acc_q))
        else $error("accumulator lost on warm reset");
    a_lpf_filter_shift: assert property (
        conv_done && fmode == adc_result_pkg::FM_LPF
        |=> acc_q == $past(acc_q) - ($past(acc_q) >>> $past(shift))
            + $signed({6'h00, $past(conv_data)}))
        else $error("low-pass step wrong");

    c_lpf_conversion: cover property (
        conv_done && fmode == adc_result_pkg::FM_LPF ##2 err_vld_q);
    c_threshold_irq: cover property (thr_evt ##1 irq);
    c_error_read: cover property (rd_en && addr == `OFS_ERR_HI);
    c_prev_from_filter: cover property (conv_start && prior_src);

endmodule : adc_result_bank
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the adc result register bank
// assumes the bank's header is on the include path, one clock at 125 mhz
`timescale 1ns/10ps
`default_nettype none
`include "adc_result_bank_defs.svh"

module tb_top;
    logic clk, rst, warm_rst, conv_start, conv_done, wr_en, rd_en, irq;
    logic [9:0] conv_data;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata, rdata;
    int error_cnt = 0;
    int check_count = 0;

    adc_result_bank adc_result_bank_inst (
        .clk(clk), .rst(rst), .warm_rst(warm_rst),
        .conv_start(conv_start), .conv_done(conv_done),
        .conv_data(conv_data), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq)
    );

    // ------------------------------------------------------------------
    // clock, reset and watchdog
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // generous: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        $display("[FAIL] watchdog expired");
        print_verdict();
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] exp,
                         input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    // read data are valid only in the cycle after the strobe edge
    task automatic rd(input logic [4:0] a, input logic [7:0] exp,
                      input string name);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        check(name, exp, rdata);
    endtask : rd

    // start one cycle ahead of done, then settle flags and interrupt
    task automatic conv(input logic [9:0] d);
        @(posedge clk);
        conv_start <= 1'b1;
        @(posedge clk);
        conv_start <= 1'b0;
        conv_done <= 1'b1;
        conv_data <= d;
        @(posedge clk);
        conv_done <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask : conv

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset_values;
        rd(`OFS_RES_LO, 8'h00, "res_lo after por");
        rd(`OFS_ACC_HI, 8'h00, "acc_hi after por");
        rd(`OFS_STPT_HI, 8'h00, "stpt_hi after por");
        rd(5'h1f, 8'h00, "unmapped read");
    endtask : t_reset_values

    // accumulate with shift 2, prior from filter, right justified
    task automatic t_accum_prior;
        wr(`OFS_ACC_HI, 8'h12);
        wr(`OFS_ACC_LO, 8'h34);
        rd(`OFS_ACC_HI, 8'h12, "acc_hi readback");
        rd(`OFS_ACC_LO, 8'h34, "acc_lo readback");
        wr(`OFS_CTRL2, 8'h2b);
        conv(10'h3ff);
        rd(`OFS_PREV_HI, 8'h04, "prev_hi filter");
        rd(`OFS_PREV_LO, 8'h8d, "prev_lo filter");
        rd(`OFS_ACC_HI, 8'h16, "acc_hi summed");
        rd(`OFS_ACC_LO, 8'h33, "acc_lo summed");
        rd(`OFS_RES_HI, 8'h03, "res_hi right");
        rd(`OFS_RES_LO, 8'hff, "res_lo right");
        // prior from the result, right then left layout
        wr(`OFS_CTRL2, 8'h21);
        conv(10'h155);
        rd(`OFS_PREV_HI, 8'h03, "prev_hi result right");
        rd(`OFS_PREV_LO, 8'hff, "prev_lo result right");
        rd(`OFS_RES_LO, 8'h55, "res_lo second");
        wr(`OFS_CTRL2, 8'h20);
        conv(10'h2a5);
        rd(`OFS_PREV_HI, 8'h01, "prev_hi keeps right");
        rd(`OFS_RES_HI, 8'ha9, "res_hi left");
        rd(`OFS_ACC_LO, 8'h2d, "acc_lo wraps in sum");
        // left layout carried into the prior bytes, sum held in basic mode
        wr(`OFS_CTRL2, 8'h1c);
        conv(10'h2a5);
        rd(`OFS_PREV_HI, 8'ha9, "prev_hi left");
        rd(`OFS_PREV_LO, 8'h40, "prev_lo left");
        rd(`OFS_ACC_HI, 8'h1a, "acc_hi basic held");
    endtask : t_accum_prior

    // data registers survive the warm reset, control does not
    task automatic t_warm_reset;
        wr(`OFS_STPT_HI, 8'h01);
        wr(`OFS_STPT_LO, 8'h00);
        @(posedge clk);
        warm_rst <= 1'b1;
        @(posedge clk);
        warm_rst <= 1'b0;
        rd(`OFS_ACC_HI, 8'h1a, "acc_hi kept");
        rd(`OFS_RES_HI, 8'ha9, "res_hi kept");
        rd(`OFS_STPT_HI, 8'h01, "stpt_hi kept");
        rd(`OFS_CTRL2, 8'h00, "ctrl2 cleared");
    endtask : t_warm_reset

    // value minus setpoint, above-upper interrupt, read-only bytes
    task automatic t_error_irq;
        wr(`OFS_CTRL2, 8'h01);
        wr(`OFS_CTRL3, 8'h21);
        wr(`OFS_LTH_HI, 8'h80);
        wr(`OFS_LTH_LO, 8'h00);
        wr(`OFS_UTH_HI, 8'hff);
        wr(`OFS_UTH_LO, 8'h00);
        wr(`OFS_IRQ_EN, 8'h02);
        conv(10'h050);
        check("irq above upper", 8'h01, {7'h00, irq});
        rd(`OFS_ERR_HI, 8'hff, "err_hi");
        rd(`OFS_ERR_LO, 8'h50, "err_lo");
        rd(`OFS_CROSS, 8'h02, "crossing flags");
        rd(`OFS_IRQ_STAT, 8'h03, "irq status");
        wr(`OFS_ERR_HI, 8'h00);
        wr(`OFS_PREV_LO, 8'h00);
        rd(`OFS_ERR_HI, 8'hff, "err_hi read only");
        rd(`OFS_PREV_LO, 8'h40, "prev_lo read only");
        wr(`OFS_IRQ_CLR, 8'h03);
        #1;
        check("irq after clear", 8'h00, {7'h00, irq});
        rd(`OFS_IRQ_STAT, 8'h00, "status after clear");
        // masked: status rises but the line stays low
        wr(`OFS_IRQ_EN, 8'h00);
        conv(10'h050);
        check("irq masked", 8'h00, {7'h00, irq});
        rd(`OFS_IRQ_STAT, 8'h03, "status while masked");
    endtask : t_error_irq

    // low-pass sum, prior from filter, error from filter-setpoint, filter-prior and value-prior sources
    task automatic t_lpf_filter;
        wr(`OFS_ACC_HI, 8'h00);
        wr(`OFS_ACC_LO, 8'h40);
        wr(`OFS_CTRL2, 8'h8a);
        wr(`OFS_CTRL3, 8'h03);
        conv(10'h100);
        rd(`OFS_PREV_LO, 8'h10, "prev_lo lpf filter");
        rd(`OFS_ACC_HI, 8'h01, "acc_hi lpf");
        rd(`OFS_ACC_LO, 8'h30, "acc_lo lpf");
        rd(`OFS_ERR_HI, 8'hff, "err_hi filt minus stpt");
        rd(`OFS_ERR_LO, 8'h4c, "err_lo filt minus stpt");
        wr(`OFS_CTRL3, 8'h02);
        conv(10'h000);
        rd(`OFS_PREV_LO, 8'h4c, "prev_lo second filter");
        rd(`OFS_ERR_LO, 8'hed, "err_lo filt minus prev");
        wr(`OFS_CTRL3, 8'h00);
        conv(10'h050);
        rd(`OFS_ERR_HI, 8'h00, "err_hi val minus prev");
        rd(`OFS_ERR_LO, 8'h17, "err_lo val minus prev");
    endtask : t_lpf_filter

    // ------------------------------------------------------------------
    // verdict and main sequence
    // ------------------------------------------------------------------
    task automatic print_verdict;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    initial begin
        rst = 1'b1;
        warm_rst = 1'b0;
        conv_start = 1'b0;
        conv_done = 1'b0;
        conv_data = 10'h000;
        addr = 5'h00;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset_values();
        t_accum_prior();
        t_warm_reset();
        t_error_irq();
        t_lpf_filter();
        print_verdict();
    end
endmodule : tb_top

`default_nettype wire
